// ### verilog/period_timer_defs.vh
/*
 holds register offsets, field positions, reset values and prescale codes
 of the period match timer. assumes inclusion by bare name from design files.
*/
`ifndef PERIOD_TIMER_DEFS_VH
`define PERIOD_TIMER_DEFS_VH

`define OFS_TIMER_CONTROL 8'h00
`define OFS_PERIOD_VALUE 8'h04
`define OFS_TIMER_COUNT 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10

`define CTRL_PRESCALE_LSB 0
`define CTRL_PRESCALE_MSB 1
`define CTRL_ON_BIT 2
`define CTRL_POSTSCALE_LSB 3
`define CTRL_POSTSCALE_MSB 6
`define CTRL_WRITE_MASK 8'h7F

`define RST_TIMER_CONTROL 8'h00
`define RST_PERIOD_VALUE 8'hFF
`define RST_TIMER_COUNT 8'h00

`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV4 2'h1
`define PRESCALE_LAST_DIV4 4'h3
`define PRESCALE_LAST_DIV16 4'hF

`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3

`endif

// ### verilog/prescale_divider.v
/*
 prescale divider: produces a one-cycle tick every 1, 4 or 16 input ticks.
 assumes the input tick is the quarter-oscillator instruction-cycle enable
 from the same clock domain.
*/
`timescale 1ns/10ps
`include "period_timer_defs.vh"

module prescale_divider (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // control
   input wire run,
   input wire clear,
   input wire [1:0] prescale_select,
   input wire tick_in,
   // result
   output wire tick_out
);

   reg [3:0] count_q;
   reg [3:0] count_d;
   reg [3:0] last;

   always @* begin
      if (prescale_select == `PRESCALE_DIV1) begin
         last = 4'h0;
      end else if (prescale_select == `PRESCALE_DIV4) begin
         last = `PRESCALE_LAST_DIV4;
      end else begin
         last = `PRESCALE_LAST_DIV16;
      end
   end

   // a clearing write swallows the tick, so the divide restarts cleanly
   assign tick_out = run & tick_in & !clear & (count_q >= last);

   always @* begin
      count_d = count_q;
      if (clear) begin
         count_d = 4'h0;
      end else if (run & tick_in) begin
         if (count_q >= last) begin
            count_d = 4'h0;
         end else begin
            count_d = count_q + 4'h1;
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= 4'h0;
      end else begin
         count_q <= count_d;
      end
   end

endmodule

// ### verilog/period_match_timer8.v
/*
 period match timer with 8-bit count, period, prescaler, postscaler and
 match interrupt, reached over an AHB-Lite slave port.
 assumes a single master, single word transfers, hclk as the only clock and
 a divide-by-four instruction-cycle tick generated here from hclk.
*/
`timescale 1ns/10ps
`include "period_timer_defs.vh"

// Operation
// - prescale field 00 divides by 1, 01 by 4, 1x by 16
// - postscale ratio is postscale field plus one
// - counter advances only while control bit 2 is one
// - count up from 00h, wrap to 00h on increment after period match
// - period register read/write, resets to FFh
// - count register read/write, reset to zero
// - matches feed 4-bit postscaler which sets the match flag
// - count or control write, or reset, clears prescaler and postscaler
// - control write keeps count value
// - control bit 7 ignores writes, reads zero
// - period match offered as a pwm time base output
module period_match_timer8 (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // timer outputs
   output reg time_base,
   output reg irq
);

   // bus state
   reg wr_pend_q;
   reg [7:0] wr_addr_q;
   reg [7:0] rd_addr;
   wire access;

   // registers
   reg [7:0] timer_control_q;
   reg [7:0] period_value_q;
   reg [7:0] timer_count_q;
   reg [7:0] timer_count_d;
   reg match_flag_q;
   reg match_irq_enable_q;
   reg [3:0] post_count_q;
   reg [3:0] post_count_d;
   reg [1:0] cycle_div_q;

   wire wr_control;
   wire wr_period;
   wire wr_count;
   wire wr_status;
   wire wr_mask;
   wire scaler_clear;
   wire timer_on;
   wire [1:0] prescale_select;
   wire [3:0] postscale_select;
   wire cycle_tick;
   wire count_tick;
   wire period_match;
   wire post_done;

   function sel_reg;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         sel_reg = (addr[7:2] == ofs[7:2]);
      end
   endfunction

   assign access = hsel & hready & (htrans == `HTRANS_NONSEQ | htrans == `HTRANS_SEQ);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         if (hready) begin
            wr_pend_q <= access & hwrite;
            wr_addr_q <= haddr;
         end
      end
   end

   assign wr_control = wr_pend_q & sel_reg(wr_addr_q, `OFS_TIMER_CONTROL);
   assign wr_period = wr_pend_q & sel_reg(wr_addr_q, `OFS_PERIOD_VALUE);
   assign wr_count = wr_pend_q & sel_reg(wr_addr_q, `OFS_TIMER_COUNT);
   assign wr_status = wr_pend_q & sel_reg(wr_addr_q, `OFS_IRQ_STATUS);
   assign wr_mask = wr_pend_q & sel_reg(wr_addr_q, `OFS_IRQ_MASK);

   assign timer_on = timer_control_q[`CTRL_ON_BIT];
   assign prescale_select = timer_control_q[`CTRL_PRESCALE_MSB:`CTRL_PRESCALE_LSB];
   assign postscale_select = timer_control_q[`CTRL_POSTSCALE_MSB:`CTRL_POSTSCALE_LSB];
   assign scaler_clear = wr_control | wr_count;

   // instruction cycle is a quarter of hclk, standing in for fosc/4
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cycle_div_q <= 2'h0;
      end else begin
         cycle_div_q <= cycle_div_q + 2'h1;
      end
   end

   assign cycle_tick = (cycle_div_q == 2'h3);

   prescale_divider u_prescale (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(timer_on),
      .clear(scaler_clear),
      .prescale_select(prescale_select),
      .tick_in(cycle_tick),
      .tick_out(count_tick)
   );

   // a prescale tick while off never comes, so count, prescaler and postscaler hold
   assign period_match = count_tick & (timer_count_q == period_value_q);
   assign post_done = period_match & (post_count_q == postscale_select);

   always @* begin
      timer_count_d = timer_count_q;
      if (wr_count) begin
         timer_count_d = hwdata[7:0];
      end else if (period_match) begin
         timer_count_d = 8'h00;
      end else if (count_tick) begin
         timer_count_d = timer_count_q + 8'h01;
      end
   end

   always @* begin
      post_count_d = post_count_q;
      if (scaler_clear) begin
         post_count_d = 4'h0;
      end else if (post_done) begin
         post_count_d = 4'h0;
      end else if (period_match) begin
         post_count_d = post_count_q + 4'h1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_control_q <= `RST_TIMER_CONTROL;
         period_value_q <= `RST_PERIOD_VALUE;
         timer_count_q <= `RST_TIMER_COUNT;
         post_count_q <= 4'h0;
         match_irq_enable_q <= 1'b0;
      end else begin
         if (wr_control) begin
            // count untouched here
            timer_control_q <= hwdata[7:0] & `CTRL_WRITE_MASK;
         end
         if (wr_period) begin
            period_value_q <= hwdata[7:0];
         end
         if (wr_mask) begin
            match_irq_enable_q <= hwdata[0];
         end
         timer_count_q <= timer_count_d;
         post_count_q <= post_count_d;
      end
   end

   // set wins over a write-one clear in the same cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         match_flag_q <= 1'b0;
      end else if (post_done) begin
         match_flag_q <= 1'b1;
      end else if (wr_status & hwdata[0]) begin
         match_flag_q <= 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         time_base <= 1'b0;
         irq <= 1'b0;
      end else begin
         time_base <= period_match;
         irq <= (match_flag_q | post_done) & match_irq_enable_q;
      end
   end

   always @* begin
      rd_addr = haddr;
      if (sel_reg(rd_addr, `OFS_TIMER_CONTROL)) begin
         rd_addr = timer_control_q;
      end else if (sel_reg(haddr, `OFS_PERIOD_VALUE)) begin
         rd_addr = period_value_q;
      end else if (sel_reg(haddr, `OFS_TIMER_COUNT)) begin
         rd_addr = timer_count_q;
      end else if (sel_reg(haddr, `OFS_IRQ_STATUS)) begin
         rd_addr = {7'h00, match_flag_q};
      end else if (sel_reg(haddr, `OFS_IRQ_MASK)) begin
         rd_addr = {7'h00, match_irq_enable_q};
      end else begin
         rd_addr = 8'h00;
      end
   end

   // read data registered from the address phase, so it stands in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (access & !hwrite) begin
            hrdata <= {24'h000000, rd_addr};
         end
      end
   end

endmodule

// ### verif/period_timer_checker.sv
/* port assertions for the period match timer.
 assumes one master, zero wait states and the designer's register map. */
`timescale 1ns/10ps
module period_timer_checker (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // bus
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // timer
   input wire time_base,
   input wire irq
);
   reg rd_q;
   reg wr_q;
   reg [7:0] ad_q;
   wire take = hsel && hready && htrans[1];
   // data phase markers, one cycle behind the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'h0;
         wr_q <= 1'h0;
         ad_q <= 8'h00;
      end else begin
         rd_q <= take && !hwrite;
         wr_q <= take && hwrite;
         ad_q <= haddr;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (!hresp) else $error("hresp not okay");
   a_base_spacing: assert property (time_base |=> !time_base [*3])
      else $error("time_base too close");
   a_irq_sticky: assert property (irq && !wr_q && !$past(wr_q) |=> irq)
      else $error("irq fell without write");
   a_irq_cause: assert property ($rose(irq) && !$past(wr_q) && !$past(wr_q, 2)
      |-> time_base)
      else $error("irq rose without match");
   a_ctrl_msb: assert property (rd_q && ad_q == 8'h00 |-> !hrdata[7])
      else $error("control bit 7 set");
   a_upper_zero: assert property (rd_q |-> hrdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_unmapped_zero: assert property (rd_q && ad_q > 8'h13 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   cover property (time_base);
   cover property ($rose(irq));
   cover property (rd_q && ad_q == 8'h00);
endmodule
bind period_match_timer8 period_timer_checker chk_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .time_base(time_base), .irq(irq));

// ### verif/period_match_timer8_test.sv
/* self-checking bench of the period match timer.
 assumes zero wait states and a hclk/4 timer tick. */
`timescale 1ns/10ps
`include "period_timer_defs.vh"
module period_match_timer8_test;
   localparam CTL = `OFS_TIMER_CONTROL;
   localparam CNT = `OFS_TIMER_COUNT;
   localparam STA = `OFS_IRQ_STATUS;
   localparam MSK = `OFS_IRQ_MASK;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] d;
   wire [31:0] hrdata;
   wire hreadyout;
   wire time_base;
   wire irq;
   integer miscompares = 0;
   integer cmp_count = 0;
   integer k, n, p;
   always #10 hclk = ~hclk;
   period_match_timer8 dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .time_base(time_base), .irq(irq));
   task report_and_stop;
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task hang;
      miscompares = miscompares + 1;
      report_and_stop;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      cmp_count = cmp_count + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wait_rdy;
      k = 0;
      do begin
         @(posedge hclk);
         k = k + 1;
      end while (hreadyout !== 1'h1 && k < 50);
      if (k >= 50) hang;
   endtask
   // read data is taken at the edge closing the data phase
   task xfer(input [7:0] a, input w, input [31:0] wd);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= `HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy;
      d = hrdata;
   endtask
   task wr(input [7:0] a, input [31:0] v);
      xfer(a, 1'h1, v);
   endtask
   task rchk(input [7:0] a, input [31:0] e);
      xfer(a, 1'h0, 32'h0);
      chk(d, e);
   endtask
   task wait_tb;
      k = 0;
      do begin
         @(posedge hclk);
         k = k + 1;
      end while (time_base !== 1'h1 && k < 2000);
      if (k >= 2000) hang;
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      rchk(CTL, 32'h0);
      rchk(`OFS_PERIOD_VALUE, 32'hFF);
      rchk(CNT, 32'h0);
      rchk(STA, 32'h0);
      wr(8'h20, 32'hFF);
      rchk(8'h20, 32'h0);
      wr(CTL, 32'hFF);
      rchk(CTL, 32'h7F);
      wr(CTL, 32'h0);
      wr(CNT, 32'h2);
      wr(CTL, 32'h2);
      rchk(CNT, 32'h2);
      repeat (100) @(posedge hclk);
      rchk(CNT, 32'h2);
      wr(`OFS_PERIOD_VALUE, 32'h3);
      wr(MSK, 32'h1);
      // first pulse after a control write is irregular, so time the second gap
      for (p = 0; p < 4; p++) begin
         wr(CTL, 32'h4 | p);
         wait_tb;
         wait_tb;
         chk(k, p == 0 ? 16 : p == 1 ? 64 : 256);
      end
      // a count write mid-prescale restarts the divide-by-16 from zero
      wait_tb;
      repeat (24) @(posedge hclk);
      wr(CNT, 32'h3);
      wait_tb;
      chk(k >= 62 && k <= 65, 32'h1);
      for (p = 0; p < 16; p++) begin
         wr(CTL, 32'h0);
         wr(STA, 32'h1);
         wr(CTL, 32'h4 | (p << 3));
         n = 0;
         k = 0;
         while (irq !== 1'h1 && k < 2000) begin
            @(posedge hclk);
            k = k + 1;
            if (time_base === 1'h1) n = n + 1;
         end
         if (k >= 2000) hang;
         chk(n, p + 1);
      end
      wr(CTL, 32'h0);
      repeat (20) @(posedge hclk);
      rchk(STA, 32'h1);
      wr(MSK, 32'h0);
      rchk(MSK, 32'h0);
      chk(irq, 32'h0);
      wr(MSK, 32'h1);
      rchk(STA, 32'h1);
      chk(irq, 32'h1);
      wr(STA, 32'h1);
      rchk(STA, 32'h0);
      chk(irq, 32'h0);
      report_and_stop;
   end
endmodule
